/* File: verilog/gddr_timing_pkg.sv */
/*
  command timing constants, command codes and the command carrier for
  the controller that spaces commands to a four-bank graphics ddr sdram.
  assumes a single 250 mhz system clock and the fastest speed grade.
*/
// Notes on behaviour
// RL1: refresh to activate or refresh waits 60 ns
// RL2: activate to read same bank waits 16 ns
// RL3: activate to write same bank waits 8 ns
// RL4: activate to write never under two cycles
// RL5: last write beat to precharge three cycles
// RL6: auto precharge write recovery three cycles
// RL7: last write beat to read two cycles
// RL8: column commands at most once per cycle
// RL9: mode register set then two idle cycles; the code leaves one idle cycle, the next command two cycles after
// RL10: auto precharge write to activate seven cycles
// RL11: self refresh exit to read 200 cycles
// RL12: power down exit three cycles plus setup
// RL13: activates to different banks 12 ns apart
// RL14: write bursts carry an even beat count
// RL15: ns minima rounded up into down-counters
// RL16: read latency picked from clock period
package gddr_timing_pkg;

  // ------------------------------------------------------------
  // clock and timing figures
  // ------------------------------------------------------------
  localparam int CLK_PS      = 4000;   // clock period in ps
  localparam int T_RFC_NS    = 60;     // refresh row cycle
  localparam int T_RCDRD_NS  = 16;     // activate to read
  localparam int T_RCDWR_NS  = 8;      // activate to write
  localparam int T_RRD_NS    = 12;     // activate to activate
  localparam int T_IS_PS     = 900;    // input setup time
  localparam int T_RCDWR_MIN = 2;      // activate to write floor, cycles
  localparam int T_WR_CK     = 3;      // last beat to precharge
  localparam int T_WR_A_CK   = 3;      // auto precharge recovery
  localparam int T_CDLR_CK   = 2;      // last beat to read
  localparam int T_CCD_CK    = 1;      // column to column
  localparam int T_MRD_CK    = 2;      // mode register set
  localparam int T_DAL_CK    = 7;      // recovery plus precharge
  localparam int T_XSR_CK    = 200;    // self refresh exit to read
  localparam int T_PDEX_CK   = 3;      // power down exit, whole cycles
  localparam int CL2_MIN_PS  = 7500;   // shortest period allowing cl 2

  // ceil division, all minima round up
  function automatic int cdiv(input int num, input int den);
    return (num + den - 1) / den;
  endfunction : cdiv

  function automatic int maxi(input int a, input int b);
    return (a > b) ? a : b;
  endfunction : maxi

  localparam int C_RFC   = cdiv(T_RFC_NS * 1000, CLK_PS);
  localparam int C_RCDRD = cdiv(T_RCDRD_NS * 1000, CLK_PS);
  localparam int C_RCDWR = maxi(cdiv(T_RCDWR_NS * 1000, CLK_PS),
                                T_RCDWR_MIN);
  localparam int C_RRD   = cdiv(T_RRD_NS * 1000, CLK_PS);
  localparam int C_PDEX  = T_PDEX_CK + cdiv(T_IS_PS, CLK_PS);
  localparam int CAS_LAT = (CLK_PS >= CL2_MIN_PS) ? 2 : 3;
  localparam int CNT_W   = 8;          // counter width, holds 200

  // ------------------------------------------------------------
  // commands
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    CMD_NOP    = 4'h0,
    CMD_ACT    = 4'h1,
    CMD_RD     = 4'h2,
    CMD_WR     = 4'h3,
    CMD_PRE    = 4'h4,
    CMD_REF    = 4'h5,
    CMD_MRS    = 4'h6,
    CMD_SRX    = 4'h7,   // self refresh exit
    CMD_PDX    = 4'h8    // power down exit
  } cmd_e;

  typedef struct packed {
    cmd_e       cmd;      // command code
    logic [1:0] bank;     // bank address
    logic       auto_pre; // auto precharge on column command
    logic [3:0] beats;    // write data beats, must be even
  } cmd_s;

  localparam int NBANK = 4;

endpackage : gddr_timing_pkg

/* File: verilog/gddr_down_cnt.sv */
/*
  loadable saturating down-counter used for every spacing.
  assumes the loader never lowers a pending wait (max on load).
*/
`timescale 1ns/100ps
module gddr_down_cnt
  import gddr_timing_pkg::*;
(
  // clock and reset
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst,
  // load side
  input  wire logic             i_load,
  input  wire logic [CNT_W-1:0] i_val,
  // state
  output logic                  o_zero
);

  logic [CNT_W-1:0] cnt_reg;   // cycles still to wait
  logic [CNT_W-1:0] cnt_next;
  logic [CNT_W-1:0] dec;
  logic [CNT_W-1:0] ld_val;    // wait less the taking cycle itself

  // a load of n lets the next take land n cycles after this one; the
  // taking cycle already counts as one, else a one-cycle spacing
  // would halve the column command rate
  assign ld_val   = (i_val != '0) ? i_val - CNT_W'(1) : i_val;
  // count down to zero, a load only ever lengthens the wait
  assign dec      = (cnt_reg != '0) ? cnt_reg - CNT_W'(1) : cnt_reg;
  assign cnt_next = (i_load && ld_val > dec) ? ld_val : dec;
  assign o_zero   = (cnt_reg == '0);

  // ------------------------------------------------------------
  // counter register
  // ------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_next;
  end

endmodule : gddr_down_cnt

/* File: verilog/gddr_cmd_timer.sv */
/*
  command spacing gate for a four-bank graphics ddr sdram.
  the user offers a command with valid; it is passed to the memory
  pins only once every spacing that binds it has run out.
  assumes the memory sits on the same 250 mhz clock.
*/
`timescale 1ns/100ps
module gddr_cmd_timer
  import gddr_timing_pkg::*;
(
  // clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  // user command side
  input  wire cmd_s       i_cmd,
  input  wire logic       i_cmd_valid,
  output logic            o_cmd_ready,
  output logic            o_cmd_reject,
  // memory command side
  output cmd_s            o_mem_cmd,
  output logic            o_mem_cmd_valid,
  output logic [1:0]      o_cas_lat
);

  // ------------------------------------------------------------
  // decode of the offered command
  // ------------------------------------------------------------
  wire is_act = (i_cmd.cmd == CMD_ACT);
  wire is_rd  = (i_cmd.cmd == CMD_RD);
  wire is_wr  = (i_cmd.cmd == CMD_WR);
  wire is_pre = (i_cmd.cmd == CMD_PRE);
  wire is_ref = (i_cmd.cmd == CMD_REF);
  wire is_mrs = (i_cmd.cmd == CMD_MRS);
  wire is_srx = (i_cmd.cmd == CMD_SRX);
  wire is_pdx = (i_cmd.cmd == CMD_PDX);
  wire is_col = is_rd | is_wr;
  // odd write bursts are refused outright
  wire bad_wr = is_wr & i_cmd.beats[0];                   // RL14

  wire fire;        // command leaves this cycle
  wire [NBANK-1:0] bsel;
  assign bsel = NBANK'(1) << i_cmd.bank;

  // global spacing done flags
  logic z_rfc, z_rrd, z_ccd, z_mrd, z_xsr, z_pdx, z_cdlr;
  // per-bank done flags
  logic [NBANK-1:0] z_rcdrd, z_rcdwr, z_wr, z_dal;

  // write end lies beats/2 cycles after the command (two beats a cycle)
  wire [CNT_W-1:0] wr_len = CNT_W'(i_cmd.beats[3:1]);

  // ------------------------------------------------------------
  // global counters
  // ------------------------------------------------------------
  gddr_down_cnt u_rfc (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_load(fire & is_ref), .i_val(CNT_W'(C_RFC)), .o_zero(z_rfc)); // RL1
  gddr_down_cnt u_rrd (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_load(fire & is_act), .i_val(CNT_W'(C_RRD)), .o_zero(z_rrd)); // RL13
  gddr_down_cnt u_ccd (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_load(fire & is_col), .i_val(CNT_W'(T_CCD_CK)),
    .o_zero(z_ccd));                                           // RL8
  gddr_down_cnt u_mrd (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_load(fire & is_mrs), .i_val(CNT_W'(T_MRD_CK)),
    .o_zero(z_mrd));                                           // RL9
  gddr_down_cnt u_xsr (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_load(fire & is_srx), .i_val(CNT_W'(T_XSR_CK)),
    .o_zero(z_xsr));                                           // RL11
  gddr_down_cnt u_pdx (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_load(fire & is_pdx), .i_val(CNT_W'(C_PDEX)),
    .o_zero(z_pdx));                                           // RL12
  gddr_down_cnt u_cdlr (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_load(fire & is_wr), .i_val(wr_len + CNT_W'(T_CDLR_CK)),
    .o_zero(z_cdlr));                                          // RL7

  // ------------------------------------------------------------
  // per-bank counters
  // ------------------------------------------------------------
  genvar b;
  generate
    for (b = 0; b < NBANK; b++)
    begin : g_bank
      wire act_b = fire & is_act & bsel[b];
      wire wr_b  = fire & is_wr & bsel[b];
      // a row must open before either column command may reach it
      gddr_down_cnt u_rd (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
        .i_load(act_b), .i_val(CNT_W'(C_RCDRD)),
        .o_zero(z_rcdrd[b]));                                  // RL2 RL15
      gddr_down_cnt u_wrd (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
        .i_load(act_b), .i_val(CNT_W'(C_RCDWR)),
        .o_zero(z_rcdwr[b]));                                  // RL3 RL4
      // write recovery before explicit precharge
      gddr_down_cnt u_wr (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
        .i_load(wr_b), .i_val(wr_len + CNT_W'(T_WR_CK)),
        .o_zero(z_wr[b]));                                     // RL5
      // auto precharge write: recovery then precharge before activate
      gddr_down_cnt u_dal (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
        .i_load(wr_b & i_cmd.auto_pre),
        .i_val(wr_len + CNT_W'(maxi(T_DAL_CK, T_WR_A_CK))),
        .o_zero(z_dal[b]));                                    // RL6 RL10
    end
  endgenerate

  // ------------------------------------------------------------
  // gate: every spacing that touches this command must be done
  // ------------------------------------------------------------
  wire mrd_ok = z_mrd & z_pdx;                 // any command waits
  wire act_ok = z_rfc & z_rrd & z_dal[i_cmd.bank];
  wire rd_ok  = z_ccd & z_rcdrd[i_cmd.bank] & z_cdlr & z_xsr;
  wire wr_ok  = z_ccd & z_rcdwr[i_cmd.bank];
  wire pre_ok = z_wr[i_cmd.bank] & z_dal[i_cmd.bank];
  wire ref_ok = z_rfc;
  wire cmd_ok = mrd_ok & (is_act ? act_ok :
                          is_rd  ? rd_ok  :
                          is_wr  ? wr_ok  :
                          is_pre ? pre_ok :
                          is_ref ? ref_ok : 1'b1);

  assign fire         = i_cmd_valid & cmd_ok & ~bad_wr;
  assign o_cmd_ready  = cmd_ok | bad_wr;     // handshake, combinational
  assign o_cmd_reject = i_cmd_valid & bad_wr;                  // RL14

  // ------------------------------------------------------------
  // registered command out to the memory pins
  // ------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_mem_cmd       <= '0;
      o_mem_cmd_valid <= 1'b0;
    end
    else
    begin
      o_mem_cmd       <= fire ? i_cmd : '0;
      o_mem_cmd_valid <= fire;
    end
  end

  // read latency fixed from the clock period
  assign o_cas_lat = 2'(CAS_LAT);                              // RL16

  // ------------------------------------------------------------
  // check helpers: cycles since the last refresh and self refresh exit, bank of the last activate
  // ------------------------------------------------------------
  wire out_ref = o_mem_cmd_valid & (o_mem_cmd.cmd == CMD_REF);
  wire out_srx = o_mem_cmd_valid & (o_mem_cmd.cmd == CMD_SRX);
  wire out_act = o_mem_cmd_valid & (o_mem_cmd.cmd == CMD_ACT);

  logic [CNT_W-1:0] since_ref_reg;   // cycles since refresh went out
  logic [CNT_W-1:0] since_ref_next;
  logic [CNT_W-1:0] since_srx_reg;   // cycles since self refresh exit
  logic [CNT_W-1:0] since_srx_next;
  logic [1:0]       act_bank_reg;    // bank of the last activate out
  logic [1:0]       act_bank_next;

  // counts saturate so a long idle spell never wraps into a short gap
  assign since_ref_next = out_ref          ? CNT_W'(1) :
                          (&since_ref_reg) ? since_ref_reg :
                          since_ref_reg + CNT_W'(1);
  assign since_srx_next = out_srx          ? CNT_W'(1) :
                          (&since_srx_reg) ? since_srx_reg :
                          since_srx_reg + CNT_W'(1);
  assign act_bank_next  = out_act ? o_mem_cmd.bank : act_bank_reg;

  // helpers start far back so the first commands count as legal
  always_ff @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      since_ref_reg <= '1;
      since_srx_reg <= '1;
      act_bank_reg  <= 2'h0;
    end
    else
    begin
      since_ref_reg <= since_ref_next;
      since_srx_reg <= since_srx_next;
      act_bank_reg  <= act_bank_next;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  property p_rfc;
    o_mem_cmd_valid && (o_mem_cmd.cmd == CMD_ACT ||
      o_mem_cmd.cmd == CMD_REF) |-> since_ref_reg >= CNT_W'(C_RFC);
  endproperty
  a_rfc: assert property (p_rfc) else $error("refresh spacing"); // RL1

  // the activate bank is held in a helper, a past value would slide
  property p_rcdrd;
    o_mem_cmd_valid && o_mem_cmd.cmd == CMD_ACT |->
      ##1 !(o_mem_cmd_valid && o_mem_cmd.cmd == CMD_RD &&
            o_mem_cmd.bank == act_bank_reg) [*3];
  endproperty
  a_rcdrd: assert property (p_rcdrd) else $error("act to read"); // RL2

  property p_rcdwr;
    o_mem_cmd_valid && o_mem_cmd.cmd == CMD_ACT |->
      ##1 !(o_mem_cmd_valid && o_mem_cmd.cmd == CMD_WR &&
            o_mem_cmd.bank == $past(o_mem_cmd.bank));
  endproperty
  a_rcdwr: assert property (p_rcdwr) else $error("act to write"); // RL3

  property p_rrd;
    o_mem_cmd_valid && o_mem_cmd.cmd == CMD_ACT |->
      ##1 !(o_mem_cmd_valid && o_mem_cmd.cmd == CMD_ACT) [*2];
  endproperty
  a_rrd: assert property (p_rrd) else $error("act to act"); // RL13

  property p_mrd;
    o_mem_cmd_valid && o_mem_cmd.cmd == CMD_MRS |-> ##1 !o_mem_cmd_valid;
  endproperty
  a_mrd: assert property (p_mrd) else $error("mrs spacing"); // RL9

  property p_pdx;
    o_mem_cmd_valid && o_mem_cmd.cmd == CMD_PDX |->
      ##1 !o_mem_cmd_valid [*3];
  endproperty
  a_pdx: assert property (p_pdx) else $error("pd exit spacing"); // RL12

  property p_even;
    o_mem_cmd_valid && o_mem_cmd.cmd == CMD_WR |-> !o_mem_cmd.beats[0];
  endproperty
  a_even: assert property (p_even) else $error("odd write"); // RL14

  property p_srx;
    o_mem_cmd_valid && o_mem_cmd.cmd == CMD_RD |->
      since_srx_reg >= CNT_W'(T_XSR_CK);
  endproperty
  a_srx: assert property (p_srx) else $error("srx to read"); // RL11

  property p_cl;
    o_cas_lat == 2'(CAS_LAT);
  endproperty
  a_cl: assert property (p_cl) else $error("latency"); // RL16

  c_act: cover property (o_mem_cmd_valid && o_mem_cmd.cmd == CMD_ACT);
  c_wr:  cover property (o_mem_cmd_valid && o_mem_cmd.cmd == CMD_WR);
  c_rd:  cover property (o_mem_cmd_valid && o_mem_cmd.cmd == CMD_RD);
  c_rej: cover property (o_cmd_reject);

endmodule : gddr_cmd_timer

/* File: test/gddr_dev_model.sv */
/*
  behavioural model of the memory device watching the command pins.
  assumes one command a cycle on the shared system clock.
*/
`timescale 1ns/100ps
module gddr_dev_model
  import gddr_timing_pkg::*;
(
  // clock and reset
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  // command pins
  input  wire cmd_s       i_mem_cmd,
  input  wire logic       i_mem_cmd_valid,
  // spacing faults seen
  output logic [7:0]      o_viol
);
  // ------------------------------------------------------------
  // spacing bookkeeping
  // ------------------------------------------------------------
  int   n, t_ref, t_act, t_mrs, t_pdx, t_srx, t_wend; // cycle stamps
  int   t_bact [NBANK];   // per-bank activate stamp
  int   t_bwend[NBANK];   // per-bank write end stamp
  logic ap     [NBANK];   // last write used auto precharge
  logic [1:0] b;          // bank of this command
  assign b = i_mem_cmd.bank;

  // stamps start far back so the first commands are legal
  always @(posedge i_clk_sys or posedge i_rst)
  begin
    if (i_rst)
    begin
      n = 0; o_viol = 8'h00;
      {t_ref, t_act, t_mrs, t_pdx, t_srx, t_wend} = {6{-1000}};
      t_bact = '{default: -1000}; t_bwend = '{default: -1000};
      ap = '{default: 1'b0};
    end
    else
    begin
      n = n + 1;
      if (i_mem_cmd_valid)
      begin
        if (n - t_mrs < T_MRD_CK) o_viol = o_viol + 8'h01;
        if (n - t_pdx < C_PDEX) o_viol = o_viol + 8'h01;
        case (i_mem_cmd.cmd)
          CMD_ACT:
          begin
            if (n - t_ref < C_RFC) o_viol = o_viol + 8'h01;
            if (n - t_act < C_RRD) o_viol = o_viol + 8'h01;
            if (ap[b] && n - t_bwend[b] < T_DAL_CK)
              o_viol = o_viol + 8'h01;
            t_act = n; t_bact[b] = n;
          end
          CMD_REF:
          begin
            if (n - t_ref < C_RFC) o_viol = o_viol + 8'h01;
            t_ref = n;
          end
          CMD_RD:
          begin
            if (n - t_bact[b] < C_RCDRD) o_viol = o_viol + 8'h01;
            if (n - t_wend < T_CDLR_CK) o_viol = o_viol + 8'h01;
            if (n - t_srx < T_XSR_CK) o_viol = o_viol + 8'h01;
          end
          CMD_WR:
          begin
            if (n - t_bact[b] < C_RCDWR) o_viol = o_viol + 8'h01;
            if (i_mem_cmd.beats[0]) o_viol = o_viol + 8'h01;
            t_wend = n + i_mem_cmd.beats / 2; // two beats a cycle
            t_bwend[b] = t_wend; ap[b] = i_mem_cmd.auto_pre;
          end
          CMD_PRE:
            if (n - t_bwend[b] < T_WR_CK) o_viol = o_viol + 8'h01;
          CMD_MRS: t_mrs = n;
          CMD_PDX: t_pdx = n;
          CMD_SRX: t_srx = n;
          default: ;
        endcase
      end
    end
  end
endmodule : gddr_dev_model

/* File: test/tb_gddr_cmd_timer.sv */
/*
  self-checking bench for the command spacing gate.
  assumes the take edge is the first ready edge after an offer.
*/
`timescale 1ns/100ps
module tb_gddr_cmd_timer;
  import gddr_timing_pkg::*;
  // ------------------------------------------------------------
  // stimulus and bookkeeping
  // ------------------------------------------------------------
  logic       clk = 1'b0, rst = 1'b1, valid = 1'b0;
  cmd_s       cmd = '0;
  cmd_s       mcmd;
  logic       mvalid, ready, reject;
  logic [1:0] cas;
  logic [7:0] viol;
  int         fails = 0, checks_done = 0, cyc = 0, tk, t0, i;
  cmd_s       cq[$];           // expected commands, oldest first
  int         tq[$];           // expected output cycles
  logic [31:0] seed = 32'd18;  // xorshift state
  logic [3:0]  bt;

  always #2 clk = ~clk;        // 250 mhz

  gddr_cmd_timer dut (.i_clk_sys(clk), .i_rst(rst), .i_cmd(cmd),
    .i_cmd_valid(valid), .o_cmd_ready(ready), .o_cmd_reject(reject),
    .o_mem_cmd(mcmd), .o_mem_cmd_valid(mvalid), .o_cas_lat(cas));
  gddr_dev_model mem (.i_clk_sys(clk), .i_rst(rst), .i_mem_cmd(mcmd),
    .i_mem_cmd_valid(mvalid), .o_viol(viol));

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic cmp(input string nm, input logic [15:0] e, s);
    checks_done++;
    if (e !== s)
    begin
      fails++;
      $display("unexpected %s: expected %h seen %h", nm, e, s);
    end
  endtask : cmp

  task automatic final_report();
    if (fails == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report

  // offer a command and expect it taken sp cycles after take rt
  task automatic issue(input cmd_e c, input logic [1:0] b,
                       input logic ap, input logic [3:0] n,
                       input int rt, input int sp);
    int eo, ex, w;
    @(negedge clk);
    cmd <= '{c, b, ap, n};
    valid <= 1'b1;
    eo = cyc + 1;
    ex = (rt + sp > eo) ? rt + sp : eo;
    #1;
    for (w = 0; ready !== 1'b1 && w < 400; w++) @(negedge clk);
    cmp("no reject", 16'h0, {15'h0, reject});
    tk = cyc + 1;
    cq.push_back(cmd);
    tq.push_back(tk);
    cmp("take cycle", ex[15:0], tk[15:0]);
    @(posedge clk);
  endtask : issue

  // each output command is matched against the oldest note
  always @(negedge clk)
    if (mvalid === 1'b1)
    begin
      if (cq.size() == 0) cmp("spare command", 16'h0, 16'h1);
      else
      begin
        cmp("mem cmd", cq.pop_front(), mcmd);
        cmp("mem cycle", tq.pop_front(), cyc[15:0]);
      end
    end

  // cycle count and hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc > 3000) begin fails++; final_report(); end
  end

  initial
  begin
    repeat (10) @(posedge clk);
    @(negedge clk) rst <= 1'b0;
    issue(CMD_MRS, 2'h0, 1'b0, 4'h0, 0, 0);
    issue(CMD_ACT, 2'h0, 1'b0, 4'h0, tk, T_MRD_CK);
    t0 = tk;
    issue(CMD_ACT, 2'h1, 1'b0, 4'h0, tk, C_RRD);
    for (i = 0; i < 3; i++)
    begin
      bt = 4'((rnd() % 4 + 1) * 2);
      issue(CMD_WR, 2'h1, 1'b0, bt, tk, i == 0 ? C_RCDWR : 1);
      issue(CMD_RD, 2'h0, 1'b0, 4'h0, tk, bt / 2 + T_CDLR_CK);
    end
    issue(CMD_RD, 2'h0, 1'b0, 4'h0, tk, T_CCD_CK);
    @(negedge clk);
    cmd <= '{CMD_WR, 2'h0, 1'b0, 4'h3};
    #1 cmp("odd reject", 16'h1, {15'h0, reject});
    @(posedge clk);
    issue(CMD_WR, 2'h0, 1'b1, 4'h2, tk, T_CCD_CK);
    issue(CMD_ACT, 2'h0, 1'b0, 4'h0, tk, 1 + T_DAL_CK);
    issue(CMD_WR, 2'h0, 1'b0, 4'h2, tk, C_RCDWR);
    issue(CMD_PRE, 2'h0, 1'b0, 4'h0, tk, 1 + T_WR_CK);
    issue(CMD_REF, 2'h0, 1'b0, 4'h0, tk, 1);
    issue(CMD_REF, 2'h0, 1'b0, 4'h0, tk, C_RFC);
    issue(CMD_ACT, 2'h3, 1'b0, 4'h0, tk, C_RFC);
    issue(CMD_PDX, 2'h0, 1'b0, 4'h0, tk, 1);
    issue(CMD_SRX, 2'h0, 1'b0, 4'h0, tk, C_PDEX);
    issue(CMD_RD, 2'h1, 1'b0, 4'h0, tk, T_XSR_CK);
    issue(CMD_ACT, 2'h2, 1'b0, 4'h0, tk, 1);
    issue(CMD_RD, 2'h2, 1'b0, 4'h0, tk, C_RCDRD);
    @(negedge clk) valid <= 1'b0;
    repeat (3) @(negedge clk);
    cmp("device faults", 16'h0, {8'h0, viol});
    cmp("read latency", 16'h3, {14'h0, cas});
    cmp("notes left", 16'h0, cq.size());
    final_report();
  end
endmodule : tb_gddr_cmd_timer
